//--- shared/mrs_defs.vh
// reset sequencer constants: delays, reset values and register widths
// assumes inclusion by the sequencer modules, their checker and the bench
`ifndef MRS_DEFS_VH
`define MRS_DEFS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MRS_STARTUP_CYCLES   11'h400
`define MRS_OPTLOAD_CYCLES   11'h010
`define MRS_DELAY_W          11

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MRS_PC_RESET         11'h000
`define MRS_SP_TOP           2'h0
`define MRS_BANK_RESET       8'h00
`define MRS_WDSEL_RESET      8'h07
`define MRS_INTERRUPT_CONTROL_RESET       6'h00
`define MRS_TIMER_CONTROL_RESET       8'h08
`define MRS_PORT_RESET       8'hFF
`define MRS_EEPROM_CONTROL_RESET       4'h8

// ----------------------------------------------------------------
// interrupt status bit positions
// ----------------------------------------------------------------
`define MRS_EV_COLD          0
`define MRS_EV_WARM          1
`define MRS_EV_READY         2
`define MRS_EV_W             3

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MRS_ADDR_W           3
`define MRS_REG_CAUSE        3'h0
`define MRS_REG_IRQ_STAT     3'h1
`define MRS_REG_IRQ_EN       3'h2
`define MRS_REG_IRQ_CLR      3'h3
`define MRS_REG_WDSEL        3'h4
`define MRS_REG_STATE        3'h5

`endif

//--- rtl/mrs_sync.v
// two-flop synchroniser for the external reset pin
// assumes the pin is asynchronous to clk_i; output reset high (pin idle)
`timescale 1ns/100ps
`default_nettype none

module mrs_sync
(
  input  wire clk_i,
  input  wire rst_n_i,
  input  wire async_i,
  output reg  sync_o
);

  reg meta;

  // only the second flop is read outside
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta   <= 1'b1;
      sync_o <= 1'b1;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

`default_nettype wire

//--- rtl/mrs_delay.v
// down counter for the start-up and option-load holds
// assumes load_i is a one-cycle pulse on clk_i
`timescale 1ns/100ps
`default_nettype none
`include "mrs_defs.vh"

module mrs_delay
(
  input  wire                    clk_i,
  input  wire                    rst_n_i,
  input  wire                    load_i,
  input  wire [`MRS_DELAY_W-1:0] count_i,
  output wire                    busy_o,
  output wire                    done_o
);

  reg [`MRS_DELAY_W-1:0] remain;

  // a fresh load restarts the hold even mid-count
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      remain <= {`MRS_DELAY_W{1'b0}};
    else if (load_i)
      remain <= count_i;
    else if (remain != {`MRS_DELAY_W{1'b0}})
      remain <= remain - 1'b1;
  end

  assign busy_o = (remain != {`MRS_DELAY_W{1'b0}});
  assign done_o = (remain == {{(`MRS_DELAY_W-1){1'b0}}, 1'b1});

endmodule

`default_nettype wire

//--- rtl/mrs_sequencer.v
// reset sequencer: cause flags, start-up and option-load holds, reset values
// assumes one 25 MHz clock; rst_n_i is the power-up reset from the supply
//
// Functional notes
// - three sources: pin reset running, pin reset halted, watchdog time-out running
// - watchdog time-out while halted is warm: only program counter and stack pointer clear
// - cause flags: power-up 00, pin u/u, pin wake 01, wdt 1/u, wdt wake 11
// - every reset and every wake holds execution 1024 clock periods
// - cold resets add an option-load hold; warm reset does not
// - chip reset: pc 000, sp top, irq off, prescaler clear, timer off, ports input
// - chip reset clears watchdog; it restarts counting straight after
// - non-warm resets load bank, wdt select, interrupt_control, timer_control, ports, eeprom values
// - pointers and accumulator untouched; timer count left undefined on non-warm resets; here timer_count_reload_o pulses on them to reload it
// - halt sets power-down, clears time-out; power-up or wdt clear clears power-down
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "mrs_defs.vh"

module mrs_sequencer
(
  input  wire                   clk_i,
  input  wire                   rst_n_i,
  input  wire                   ext_reset_n_i,
  input  wire                   wdt_timeout_i,
  input  wire                   halt_exec_i,
  input  wire                   wdt_clear_exec_i,
  input  wire                   wake_event_i,
  input  wire [`MRS_ADDR_W-1:0] addr_i,
  input  wire [7:0]             wdata_i,
  input  wire                   wr_i,
  input  wire                   rd_i,
  output reg  [7:0]             rdata_o,
  output reg                    irq_o,
  output reg                    cpu_run_o,
  output reg                    halted_o,
  output reg                    timeout_cause_flag_o,
  output reg                    powerdown_cause_flag_o,
  output reg                    pc_clear_o,
  output reg                    sp_clear_o,
  output reg                    chip_reset_o,
  output reg                    watchdog_clear_o,
  output reg                    timer_count_reload_o,
  output reg  [7:0]             bank_pointer_o,
  output reg  [7:0]             watchdog_prescale_select_o,
  output reg  [5:0]             interrupt_control_o,
  output reg  [7:0]             timer_control_o,
  output reg  [7:0]             port_data_o,
  output reg  [7:0]             port_a_direction_o,
  output reg  [3:0]             eeprom_control_o
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_RUN     = 3'h0;
  localparam ST_HALT    = 3'h1;
  localparam ST_PINHOLD = 3'h2;
  localparam ST_OPTLOAD = 3'h3;
  localparam ST_STARTUP = 3'h4;

  reg  [2:0]                state;
  reg  [2:0]                next_state;
  reg                       pin_was_halt;
  reg  [`MRS_EV_W-1:0]      irq_stat;
  reg  [`MRS_EV_W-1:0]      irq_en;
  reg  [`MRS_EV_W-1:0]      ev;
  reg                       dly_load;
  reg  [`MRS_DELAY_W-1:0]   dly_count;
  reg                       cold_req;
  reg                       warm_req;
  wire                      pin_n;
  wire                      dly_busy;
  wire                      dly_done;
  wire                      pin_low;

  // ----------------------------------------------------------------
  // pin synchroniser and hold counter
  // ----------------------------------------------------------------
  mrs_sync u_sync
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (ext_reset_n_i),
    .sync_o  (pin_n)
  );

  mrs_delay u_delay
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .load_i  (dly_load),
    .count_i (dly_count),
    .busy_o  (dly_busy),
    .done_o  (dly_done)
  );

  assign pin_low = ~pin_n;

  // ----------------------------------------------------------------
  // next state and hold loading
  // ----------------------------------------------------------------
  // the pin outranks the watchdog since it also clears the watchdog
  always @*
  begin
    next_state = state;
    dly_load   = 1'b0;
    dly_count  = `MRS_STARTUP_CYCLES;
    cold_req   = 1'b0;
    warm_req   = 1'b0;
    case (state)
      ST_RUN:
      begin
        if (pin_low)
        begin
          next_state = ST_PINHOLD;
          cold_req   = 1'b1;
        end
        else if (wdt_timeout_i)
        begin
          next_state = ST_OPTLOAD;
          cold_req   = 1'b1;
          dly_load   = 1'b1;
          dly_count  = `MRS_OPTLOAD_CYCLES;
        end
        else if (halt_exec_i)
          next_state = ST_HALT;
      end
      ST_HALT:
      begin
        if (pin_low)
        begin
          next_state = ST_PINHOLD;
          cold_req   = 1'b1;
        end
        else if (wdt_timeout_i)
        begin
          next_state = ST_STARTUP;
          warm_req   = 1'b1;
          dly_load   = 1'b1;
        end
        else if (wake_event_i)
        begin
          next_state = ST_STARTUP;
          dly_load   = 1'b1;
        end
      end
      ST_PINHOLD:
      begin
        // held in reset as long as the pin stays low
        if (!pin_low)
        begin
          next_state = ST_OPTLOAD;
          dly_load   = 1'b1;
          dly_count  = `MRS_OPTLOAD_CYCLES;
        end
      end
      ST_OPTLOAD:
      begin
        if (pin_low)
          next_state = ST_PINHOLD;
        else if (dly_done || !dly_busy)
        begin
          next_state = ST_STARTUP;
          dly_load   = 1'b1;
        end
      end
      ST_STARTUP:
      begin
        if (pin_low)
        begin
          next_state = ST_PINHOLD;
          cold_req   = 1'b1;
        end
        else if (dly_done || !dly_busy)
          next_state = ST_RUN;
      end
      default:
        next_state = ST_PINHOLD;
    endcase
  end

  // ----------------------------------------------------------------
  // state register and cause flags
  // ----------------------------------------------------------------
  // power-up enters the option-load path as a cold reset
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state                  <= ST_PINHOLD;
      pin_was_halt           <= 1'b0;
      timeout_cause_flag_o   <= 1'b0;
      powerdown_cause_flag_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == ST_RUN && pin_low)
        pin_was_halt <= 1'b0;
      else if (state == ST_HALT && pin_low)
        pin_was_halt <= 1'b1;
      // pin wake from halt reports 0,1; pin in running leaves flags alone unless a halt or wdt clear comes in the same cycle
      if (state == ST_PINHOLD && !pin_low && pin_was_halt)
      begin
        timeout_cause_flag_o   <= 1'b0;
        powerdown_cause_flag_o <= 1'b1;
      end
      else if (state == ST_RUN && !pin_low && wdt_timeout_i)
        timeout_cause_flag_o <= 1'b1;
      else if (warm_req)
      begin
        timeout_cause_flag_o   <= 1'b1;
        powerdown_cause_flag_o <= 1'b1;
      end
      else if (state == ST_RUN && halt_exec_i)
      begin
        powerdown_cause_flag_o <= 1'b1;
        timeout_cause_flag_o   <= 1'b0;
      end
      else if (state == ST_RUN && wdt_clear_exec_i)
        powerdown_cause_flag_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // strobes, run status and reset values
  // ----------------------------------------------------------------
  // pointers and accumulator have no reset path here at all
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cpu_run_o            <= 1'b0;
      halted_o             <= 1'b0;
      pc_clear_o           <= 1'b1;
      sp_clear_o           <= 1'b1;
      chip_reset_o         <= 1'b1;
      watchdog_clear_o     <= 1'b1;
      timer_count_reload_o <= 1'b1;
    end
    else
    begin
      cpu_run_o    <= (next_state == ST_RUN);
      halted_o     <= (next_state == ST_HALT);
      pc_clear_o   <= cold_req || warm_req || (state == ST_PINHOLD);
      sp_clear_o   <= cold_req || warm_req || (state == ST_PINHOLD);
      chip_reset_o <= cold_req || (state == ST_PINHOLD);
      // released with the chip reset so the watchdog recounts at once
      watchdog_clear_o     <= cold_req || (state == ST_PINHOLD);
      timer_count_reload_o <= cold_req;
    end
  end

  // ----------------------------------------------------------------
  // reset-valued registers and software access
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!rst_n_i || cold_req || state == ST_PINHOLD)
    begin
      bank_pointer_o             <= `MRS_BANK_RESET;
      watchdog_prescale_select_o <= `MRS_WDSEL_RESET;
      interrupt_control_o        <= `MRS_INTERRUPT_CONTROL_RESET;
      timer_control_o            <= `MRS_TIMER_CONTROL_RESET;
      port_data_o                <= `MRS_PORT_RESET;
      port_a_direction_o         <= `MRS_PORT_RESET;
      eeprom_control_o           <= `MRS_EEPROM_CONTROL_RESET;
    end
    else if (wr_i && addr_i == `MRS_REG_WDSEL)
      watchdog_prescale_select_o <= wdata_i;
  end

  // ----------------------------------------------------------------
  // interrupt status, enable and read port
  // ----------------------------------------------------------------
  always @*
  begin
    ev                = {`MRS_EV_W{1'b0}};
    ev[`MRS_EV_COLD]  = cold_req;
    ev[`MRS_EV_WARM]  = warm_req;
    ev[`MRS_EV_READY] = (state == ST_STARTUP) && (next_state == ST_RUN);
  end

  // a new event wins over a clear in the same cycle
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_stat <= {`MRS_EV_W{1'b0}};
      irq_en   <= {`MRS_EV_W{1'b0}};
      irq_o    <= 1'b0;
      rdata_o  <= 8'h00;
    end
    else
    begin
      if (wr_i && addr_i == `MRS_REG_IRQ_CLR)
        irq_stat <= (irq_stat & ~wdata_i[`MRS_EV_W-1:0]) | ev;
      else
        irq_stat <= irq_stat | ev;
      if (wr_i && addr_i == `MRS_REG_IRQ_EN)
        irq_en <= wdata_i[`MRS_EV_W-1:0];
      irq_o <= |(irq_stat & irq_en);
      rdata_o <= 8'h00;
      if (rd_i)
      begin
        case (addr_i)
          `MRS_REG_CAUSE:    rdata_o <= {6'h00, timeout_cause_flag_o, powerdown_cause_flag_o};
          `MRS_REG_IRQ_STAT: rdata_o <= {5'h00, irq_stat};
          `MRS_REG_IRQ_EN:   rdata_o <= {5'h00, irq_en};
          `MRS_REG_WDSEL:    rdata_o <= watchdog_prescale_select_o;
          `MRS_REG_STATE:    rdata_o <= {5'h00, state};
          default:           rdata_o <= 8'h00;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

//--- testbench/mrs_seq_chk.sv
// checker for the reset sequencer: hold lengths, cause flags, reset values
// assumes it is bound to mrs_sequencer and sees only its ports
`timescale 1ns/100ps
`default_nettype none
`include "mrs_defs.vh"

module mrs_seq_chk
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       ext_reset_n_i,
  input wire logic       wdt_timeout_i,
  input wire logic       halt_exec_i,
  input wire logic       cpu_run_o,
  input wire logic       halted_o,
  input wire logic       timeout_cause_flag_o,
  input wire logic       powerdown_cause_flag_o,
  input wire logic       pc_clear_o,
  input wire logic       sp_clear_o,
  input wire logic       chip_reset_o,
  input wire logic       watchdog_clear_o,
  input wire logic       timer_count_reload_o,
  input wire logic [7:0] bank_pointer_o,
  input wire logic [5:0] interrupt_control_o,
  input wire logic [7:0] timer_control_o,
  input wire logic [7:0] port_data_o,
  input wire logic [7:0] port_a_direction_o,
  input wire logic [3:0] eeprom_control_o
);
  logic [10:0] cnt;
  logic        cold;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // --------------------------------------------------------------
  // hold length helper
  // --------------------------------------------------------------
  // halt time and the chip reset itself are not part of the hold
  always @(posedge clk_i)
  begin
    if (!rst_n_i || cpu_run_o || halted_o || chip_reset_o)
      cnt <= 11'h000;
    else
      cnt <= cnt + 11'h001;
    if (!rst_n_i || chip_reset_o)
      cold <= 1'b1;
    else if (cpu_run_o)
      cold <= 1'b0;
  end

  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  property p_reset_clears;
    chip_reset_o |-> pc_clear_o && sp_clear_o && watchdog_clear_o && !cpu_run_o;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("chip reset clears");
  property p_reset_values;
    chip_reset_o |=> {bank_pointer_o, interrupt_control_o, timer_control_o, port_data_o,
      port_a_direction_o, eeprom_control_o} == {`MRS_BANK_RESET, `MRS_INTERRUPT_CONTROL_RESET,
      `MRS_TIMER_CONTROL_RESET, `MRS_PORT_RESET, `MRS_PORT_RESET, `MRS_EEPROM_CONTROL_RESET};
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values");
  property p_warm_keep;
    pc_clear_o && !chip_reset_o |-> $stable(bank_pointer_o) && $stable(port_data_o)
      && $stable(interrupt_control_o) && $stable(timer_control_o);
  endproperty
  a_warm_keep: assert property (p_warm_keep) else $error("warm reset touched");
  property p_warm_wake;
    halted_o && wdt_timeout_i && ext_reset_n_i |-> ##[1:3] (pc_clear_o && sp_clear_o
      && !chip_reset_o);
  endproperty
  a_warm_wake: assert property (p_warm_wake) else $error("warm wake clears");
  property p_halt_flags;
    halt_exec_i && cpu_run_o && ext_reset_n_i && !wdt_timeout_i |-> ##[1:3]
      (powerdown_cause_flag_o && !timeout_cause_flag_o);
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags");
  property p_pin_hold;
    !ext_reset_n_i [*5] |-> chip_reset_o && !cpu_run_o;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin low not in reset");
  property p_startup;
    $rose(cpu_run_o) && !cold |-> cnt >= 11'h3FC && cnt <= 11'h406;
  endproperty
  a_startup: assert property (p_startup) else $error("start-up hold length");
  property p_optload;
    $rose(cpu_run_o) && cold |-> cnt >= 11'h40E && cnt <= 11'h41A;
  endproperty
  a_optload: assert property (p_optload) else $error("option-load hold length");
  property p_reload;
    timer_count_reload_o |-> chip_reset_o;
  endproperty
  a_reload: assert property (p_reload) else $error("timer reload outside reset");
endmodule
`default_nettype wire

//--- testbench/mrs_pin_model.sv
// external reset network model driving the active-low reset pin
// assumes go_i is a one-cycle request; the pin is pulled high when idle
`timescale 1ns/100ps
`default_nettype none

module mrs_pin_model
(
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] len_i,
  output var  logic       pin_n_o
);
  logic [7:0] left = 8'h00;

  // hold the pin low for len_i cycles, long enough for the synchroniser
  always @(posedge clk_i)
  begin
    if (go_i)
      left <= len_i;
    else if (left != 8'h00)
      left <= left - 8'h01;
  end

  // released pin returns to the pull-up level
  always @*
    pin_n_o = (left == 8'h00);
endmodule
`default_nettype wire

//--- testbench/mcu_reset_sequencer_bench.sv
// self-checking bench for the reset sequencer
// assumes mrs_sequencer, mrs_pin_model and mrs_seq_chk are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "mrs_defs.vh"

module mcu_reset_sequencer_bench;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [3:0] ev = 4'h0;
  logic       pin_go = 1'b0;
  logic [7:0] pin_len = 8'h00;
  logic       pin_n;
  logic [7:0] rdata_o;
  logic       irq_o, cpu_run_o, halted_o, chip_reset_o, rd_d;
  logic [7:0] lfsr = 8'h57;
  logic [7:0] rnd;
  logic [7:0] exp_q[$];
  int         n_errors = 0;
  int         check_count = 0;

  mrs_sequencer mrs_sequencer_i
  (
    .clk_i, .rst_n_i, .ext_reset_n_i(pin_n), .wdt_timeout_i(ev[0]), .halt_exec_i(ev[1]),
    .wdt_clear_exec_i(ev[2]), .wake_event_i(ev[3]), .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .irq_o, .cpu_run_o, .halted_o, .timeout_cause_flag_o(),
    .powerdown_cause_flag_o(), .pc_clear_o(), .sp_clear_o(), .chip_reset_o,
    .watchdog_clear_o(), .timer_count_reload_o(), .bank_pointer_o(),
    .watchdog_prescale_select_o(), .interrupt_control_o(), .timer_control_o(),
    .port_data_o(), .port_a_direction_o(), .eeprom_control_o()
  );

  mrs_pin_model mrs_pin_model_i (.clk_i, .go_i(pin_go), .len_i(pin_len), .pin_n_o(pin_n));

  // 40 ns clock
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // pseudo-random source shared by every random field of the scenarios
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // each strobe is followed by an idle edge so no signal is driven twice at once
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // ev bits: watchdog time-out, halt, watchdog clear, wake
  task automatic pulse(input logic [3:0] m);
    ev <= m;
    @(posedge clk_i);
    ev <= 4'h0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic pin_reset;
    lfsr = lfsr_next(lfsr);
    pin_len <= {3'h0, lfsr[4:0]} + 8'h08;
    pin_go <= 1'b1;
    @(posedge clk_i);
    pin_go <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  // bounded wait for execution to resume
  task automatic wait_run;
    int i;
    i = 0;
    while (cpu_run_o !== 1'b1 && i < 1300)
    begin
      @(posedge clk_i);
      i++;
    end
    check({7'h00, cpu_run_o}, 8'h01);
  endtask

  // read data stand only in the cycle after the strobe; oldest note first
  always @(posedge clk_i)
  begin
    rd_d <= rd_i;
    if (rd_d)
      check(rdata_o, exp_q.pop_front());
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wait_run;
    rd(3'h0, 8'h00);
    rd(3'h4, `MRS_WDSEL_RESET);
    rd(3'h7, 8'h00);
    wr(3'h3, 8'h07);
    wr(3'h2, 8'h07);
    rd(3'h1, 8'h00);
    check({7'h00, irq_o}, 8'h00);
    pulse(4'h1);
    wait_run;
    rd(3'h0, 8'h02);
    lfsr = lfsr_next(lfsr);
    rnd = lfsr;
    wr(3'h4, rnd);
    rd(3'h4, rnd);
    wr(3'h0, 8'h03);
    rd(3'h0, 8'h02);
    pulse(4'h2);
    check({7'h00, halted_o}, 8'h01);
    rd(3'h0, 8'h01);
    pulse(4'h8);
    wait_run;
    rd(3'h0, 8'h01);
    wr(3'h3, 8'h07);
    pulse(4'h2);
    pulse(4'h1);
    wait_run;
    rd(3'h0, 8'h03);
    rd(3'h4, rnd);
    rd(3'h1, 8'h06);
    check({7'h00, irq_o}, 8'h01);
    // irq_o is registered from status and enable, so it trails each write by an edge
    wr(3'h2, 8'h00);
    @(posedge clk_i);
    check({7'h00, irq_o}, 8'h00);
    wr(3'h2, 8'h02);
    @(posedge clk_i);
    check({7'h00, irq_o}, 8'h01);
    wr(3'h3, 8'h02);
    @(posedge clk_i);
    check({7'h00, irq_o}, 8'h00);
    rd(3'h1, 8'h04);
    pin_reset;
    check({7'h00, chip_reset_o}, 8'h01);
    wait_run;
    rd(3'h0, 8'h03);
    rd(3'h4, `MRS_WDSEL_RESET);
    pulse(4'h2);
    pin_reset;
    wait_run;
    rd(3'h0, 8'h01);
    pulse(4'h4);
    rd(3'h0, 8'h00);
    end_sim;
  end

  // hang guard, well beyond six start-up holds
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    end_sim;
  end
endmodule

bind mrs_sequencer mrs_seq_chk mrs_seq_chk_i
(
  .clk_i, .rst_n_i, .ext_reset_n_i, .wdt_timeout_i, .halt_exec_i, .cpu_run_o, .halted_o,
  .timeout_cause_flag_o, .powerdown_cause_flag_o, .pc_clear_o, .sp_clear_o, .chip_reset_o,
  .watchdog_clear_o, .timer_count_reload_o, .bank_pointer_o, .interrupt_control_o,
  .timer_control_o, .port_data_o, .port_a_direction_o, .eeprom_control_o
);
`default_nettype wire
